/* shared/crc_pkg.sv */
// Package: register map, field positions and types of the CRC generator
package crc_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_DATA = 12'h420;
    localparam logic [11:0] OFS_RESULT = 12'h430;
    localparam logic [11:0] OFS_CTRL = 12'ha00;
    localparam logic [11:0] OFS_POLY = 12'ha10;
    localparam logic [11:0] OFS_ISTAT = 12'ha40;
    localparam logic [11:0] OFS_IMASK = 12'ha50;
    // Alias operation in address bits 3:2
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
    localparam logic [31:0] POLY_RESET = 32'h0000_0000;
    localparam logic [31:0] POLY_WMASK = 32'hffff_fffe;
    // Writable control bits: width, length, on, idle stop, isel..mode
    localparam logic [31:0] CTRL_WMASK = 32'h1f1f_a03c;
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] CAP_BYTE = 5'h10;
    localparam logic [4:0] CAP_HALF = 5'h08;
    localparam logic [4:0] CAP_WORD = 5'h04;
    localparam logic [4:0] DW_BYTE_MAX = 5'h07;
    localparam logic [4:0] DW_HALF_MAX = 5'h0f;
    localparam int ISTAT_DONE = 0;

    typedef struct packed {
        logic [2:0] rsv_hi;
        logic [4:0] data_width_minus_one;
        logic [2:0] rsv_mid;
        logic [4:0] poly_length_minus_one;
        logic enable;
        logic rsv_14;
        logic idle_stop;
        logic [4:0] fifo_word_count;
        logic fifo_full_flag;
        logic fifo_empty_flag;
        logic interrupt_source_select;
        logic shifter_start;
        logic lsb_first_select;
        logic calc_alternate_select;
        logic [1:0] rsv_lo;
    } crc_ctrl_t;

    localparam crc_ctrl_t CTRL_RESET = 32'h0000_0040;
endpackage : crc_pkg

/* design/crc_gen.sv */
// Programmable CRC generator with data FIFO and AXI4-Lite registers
`timescale 1ns/1ns
module crc_gen
    import crc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Device power state
    input wire logic idle_mode,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);

    crc_ctrl_t ctrl_r;
    logic [31:0] poly_r, data_r, crc_r, istat_r, imask_r, rdata_r, shreg_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, irq_r, busy_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] fifo_mem [FIFO_DEPTH];
    logic [3:0] wr_ptr_r, rd_ptr_r;
    logic [4:0] count_r, bitcnt_r;
    logic wr_fire, rd_fire;
    logic [11:0] wbase, rbase;
    logic [1:0] wop;
    logic [31:0] wmask_bytes;
    logic run, push, pop, fifo_full, fifo_empty;
    logic [4:0] cap;
    logic shift_bit, fb, last_bit, done_evt, empty_evt;
    logic [31:0] len_mask, crc_nxt, ctrl_rd, mapped_rd;
    logic w_map, r_map;

    // Alias operation applied to the writable bits of one register
    function automatic logic [31:0] apply_op(input logic [31:0] old,
        input logic [31:0] wd, input logic [1:0] op,
        input logic [31:0] wm);
        logic [31:0] v;
        unique case (op)
            OP_WRITE: v = wd;
            OP_CLR: v = old & ~wd;
            OP_SET: v = old | wd;
            OP_INV: v = old ^ wd;
        endcase
        return (old & ~wm) | (v & wm);
    endfunction : apply_op

    assign wr_fire = awready_r && s_axi_awvalid && wready_r &&
        s_axi_wvalid;
    assign rd_fire = arready_r && s_axi_arvalid;
    assign wbase = {s_axi_awaddr[11:4], 4'h0};
    assign wop = s_axi_awaddr[3:2];
    assign rbase = {s_axi_araddr[11:4], 4'h0};

    generate
        for (genvar gi = 0; gi < 4; gi++) begin : g_lane
            assign wmask_bytes[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
        end
    endgenerate

    assign w_map = (wbase == OFS_DATA) || (wbase == OFS_RESULT) ||
        (wbase == OFS_CTRL) || (wbase == OFS_POLY) ||
        (wbase == OFS_ISTAT) || (wbase == OFS_IMASK);

    // Running state: enabled and not halted by idle
    assign run = ctrl_r.enable &&
        !(ctrl_r.idle_stop && idle_mode);

    // FIFO capacity follows the data word width
    always_comb begin
        if (ctrl_r.data_width_minus_one <= DW_BYTE_MAX) begin
            cap = CAP_BYTE;
        end else if (ctrl_r.data_width_minus_one <= DW_HALF_MAX) begin
            cap = CAP_HALF;
        end else begin
            cap = CAP_WORD;
        end
    end

    assign fifo_full = (count_r >= cap);
    assign fifo_empty = (count_r == 5'h00);
    assign push = wr_fire && (wbase == OFS_DATA) && ctrl_r.enable &&
        !fifo_full;
    assign pop = run && ctrl_r.shifter_start && !busy_r && !fifo_empty;

    // FIFO storage
    always_ff @(posedge aclk) begin
        if (push) begin
            fifo_mem[wr_ptr_r] <= apply_op(data_r, s_axi_wdata, wop,
                wmask_bytes);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_r.enable) begin
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
            count_r <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 4'h1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 4'h1;
            end
            if (push && !pop) begin
                count_r <= count_r + 5'h01;
            end else if (pop && !push) begin
                count_r <= count_r - 5'h01;
            end
        end
    end

    // Serial shifter: one data bit per cycle
    assign shift_bit = ctrl_r.lsb_first_select ? shreg_r[0] :
        shreg_r[ctrl_r.data_width_minus_one];
    assign last_bit = busy_r && (bitcnt_r == 5'h00);
    assign len_mask = 32'hffff_ffff >>
        (5'h1f - ctrl_r.poly_length_minus_one);

    always_comb begin
        // Alternate: direct form; legacy: augmented form
        if (ctrl_r.calc_alternate_select) begin
            fb = crc_r[ctrl_r.poly_length_minus_one] ^ shift_bit;
            crc_nxt = {crc_r[30:0], 1'b0};
        end else begin
            fb = crc_r[ctrl_r.poly_length_minus_one];
            crc_nxt = {crc_r[30:0], shift_bit};
        end
        if (fb) begin
            crc_nxt = crc_nxt ^ {poly_r[31:1], 1'b1};
        end
        crc_nxt = crc_nxt & len_mask;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_r <= 1'b0;
            shreg_r <= 32'h0000_0000;
            bitcnt_r <= 5'h00;
        end else if (!ctrl_r.shifter_start || !ctrl_r.enable) begin
            busy_r <= 1'b0;
        end else if (run) begin
            if (pop) begin
                busy_r <= 1'b1;
                shreg_r <= fifo_mem[rd_ptr_r];
                bitcnt_r <= ctrl_r.data_width_minus_one;
            end else if (busy_r) begin
                if (ctrl_r.lsb_first_select) begin
                    shreg_r <= {1'b0, shreg_r[31:1]};
                end else begin
                    shreg_r <= {shreg_r[30:0], 1'b0};
                end
                bitcnt_r <= bitcnt_r - 5'h01;
                if (last_bit) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // Result register: software preset wins over a shift step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crc_r <= RESULT_RESET;
        end else if (wr_fire && wbase == OFS_RESULT) begin
            crc_r <= apply_op(crc_r, s_axi_wdata, wop,
                wmask_bytes);
        end else if (run && busy_r && ctrl_r.shifter_start) begin
            crc_r <= crc_nxt;
        end
    end

    // Interrupt events
    assign empty_evt = pop && (count_r == 5'h01) && !push;
    assign done_evt = run && ctrl_r.shifter_start && last_bit &&
        fifo_empty;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= 32'h0000_0000;
        end else begin
            if (wr_fire && wbase == OFS_ISTAT) begin
                istat_r <= istat_r & ~(s_axi_wdata & wmask_bytes);
            end
            // Set wins over a simultaneous clear
            if (ctrl_r.interrupt_source_select ? empty_evt :
                done_evt) begin
                istat_r[ISTAT_DONE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(istat_r & imask_r);
        end
    end

    // Software-written registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RESET;
            poly_r <= POLY_RESET;
            data_r <= DATA_RESET;
            imask_r <= 32'h0000_0000;
        end else if (wr_fire) begin
            unique case (wbase)
                OFS_CTRL: ctrl_r <= apply_op(ctrl_r, s_axi_wdata, wop,
                    CTRL_WMASK & wmask_bytes);
                OFS_POLY: poly_r <= apply_op(poly_r, s_axi_wdata, wop,
                    POLY_WMASK & wmask_bytes);
                OFS_DATA: data_r <= apply_op(data_r, s_axi_wdata, wop,
                    wmask_bytes);
                OFS_IMASK: imask_r <= apply_op(imask_r, s_axi_wdata,
                    wop, wmask_bytes);
                default: ;
            endcase
        end
    end

    // Control read view with live status fields
    always_comb begin
        crc_ctrl_t c;
        c = ctrl_r & CTRL_WMASK;
        c.fifo_word_count = count_r;
        c.fifo_full_flag = fifo_full;
        c.fifo_empty_flag = fifo_empty;
        ctrl_rd = c;
    end

    always_comb begin
        r_map = 1'b1;
        unique case (rbase)
            OFS_DATA: mapped_rd = data_r;
            OFS_RESULT: mapped_rd = crc_r;
            OFS_CTRL: mapped_rd = ctrl_rd;
            OFS_POLY: mapped_rd = poly_r & POLY_WMASK;
            OFS_ISTAT: mapped_rd = istat_r;
            OFS_IMASK: mapped_rd = imask_r;
            default: begin
                mapped_rd = 32'h0000_0000;
                r_map = 1'b0;
            end
        endcase
    end

    // AXI4-Lite write channel: take address and data together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= w_map ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r) begin
            if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end else if (s_axi_awvalid && s_axi_wvalid) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (rd_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= mapped_rd;
            rresp_r <= r_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r) begin
            if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign irq = irq_r;
endmodule : crc_gen

/* tb/crc_gen_asserts.sv */
// Register bus and interrupt checks for the CRC generator
`timescale 1ns/1ns
module crc_gen_asserts
    import crc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_AW_W_PAIRED: assert property (
        s_axi_awready == s_axi_wready) else $error("aw w split");
    AST_AW_PULSE: assert property (
        s_axi_awready |=> !s_axi_awready) else $error("aw held");
    AST_WRITE_TAKEN: assert property (
        $rose(s_axi_awvalid) |-> ##[1:4] s_axi_awready)
        else $error("write not taken");
    AST_B_NEXT: assert property (
        s_axi_awready |=> s_axi_bvalid) else $error("no write answer");
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_READ_TAKEN: assert property (
        $rose(s_axi_arvalid) |-> ##[1:4] s_axi_arready)
        else $error("read not taken");
    AST_R_NEXT: assert property (
        s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_ERR_ZERO: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read not zero");
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("busy after reset");

    cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : crc_gen_asserts

bind crc_gen crc_gen_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq)
);

/* tb/tb.sv */
// Self-checking bench for the CRC generator
`timescale 1ns/1ns
module tb
    import crc_pkg::*;
;
    logic aclk, aresetn, idle_mode, irq;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int bad_count = 0;
    int n_compared = 0;
    int dws[4] = '{7, 15, 31, 7};
    int pls[4] = '{7, 3, 31, 12};

    crc_gen dut (
        .aclk(aclk), .aresetn(aresetn), .idle_mode(idle_mode),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic finish_test;
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic hang;
        bad_count++;
        finish_test();
    endtask : hang

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // A random first bready is set high again before bvalid can rise, so the answer is never held
        bready <= 1'($urandom);
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            bready <= 1'b1;
        end
        bready <= 1'b0;
        if (n == 50) hang();
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'($urandom);
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            rready <= 1'b1;
        end
        rready <= 1'b0;
        if (n == 50) hang();
        d = rdata;
        r = rresp;
    endtask : rd

    task automatic rc(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rc

    // Reference shift of every queued word, bit by bit
    function automatic logic [31:0] crc_ref(logic [31:0] c,
        logic [31:0] q[$], logic [31:0] poly, int dw, int pl, bit alt,
        bit lsb);
        logic [63:0] crc = {32'h0, c};
        logic [63:0] pv = {32'h0, poly[31:1], 1'b1};
        logic [63:0] msk = (64'h1 << (pl + 1)) - 64'h1;
        bit b;
        bit fb;
        foreach (q[j]) for (int k = 0; k <= dw; k++) begin
            b = lsb ? q[j][k] : q[j][dw - k];
            fb = crc[pl] ^ (alt & b);
            crc = alt ? (crc << 1) : ((crc << 1) | {63'h0, b});
            if (fb) crc = crc ^ pv;
            crc = crc & msk;
        end
        return crc[31:0];
    endfunction : crc_ref

    initial begin
        logic [11:0] adr[6];
        logic [31:0] v, p, cfg, res;
        logic [31:0] q[$];
        logic [1:0] r;
        int i, k, n, cap;
        adr = '{OFS_DATA, OFS_RESULT, OFS_CTRL, OFS_POLY, OFS_ISTAT,
                OFS_IMASK};
        aresetn = 1'b0;
        idle_mode = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = '0;
        void'($urandom(13453));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++)
            rc(adr[i], (i == 2) ? 32'h40 : 32'h0, RESP_OKAY);
        wr(12'h100, 32'h1, RESP_SLVERR);
        rc(12'h100, 32'h0, RESP_SLVERR);
        p = 32'h0;
        for (k = 0; k < 4; k++) begin
            v = $urandom;
            wr(OFS_POLY + 12'(k * 4), v, RESP_OKAY);
            case (k)
                0: p = v;
                1: p = p & ~v;
                2: p = p | v;
                default: p = p ^ v;
            endcase
            p[0] = 1'b0;
            rc(OFS_POLY, p, RESP_OKAY);
        end
        wr(OFS_DATA, 32'h5a, RESP_OKAY);
        rc(OFS_CTRL, 32'h40, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            cap = (dws[i] <= 7) ? 16 : (dws[i] <= 15) ? 8 : 4;
            p = $urandom & 32'hffff_fffe;
            wr(OFS_POLY, p, RESP_OKAY);
            res = $urandom & 32'((64'h1 << (pls[i] + 1)) - 64'h1);
            wr(OFS_RESULT, res, RESP_OKAY);
            wr(OFS_IMASK, {31'h0, i[0]}, RESP_OKAY);
            cfg = {3'h0, 5'(dws[i]), 3'h0, 5'(pls[i]), 2'h2, i == 2, 7'h0,
                   i == 3, 1'b0, i[1], i[0], 2'h0};
            idle_mode <= i[0];
            wr(OFS_CTRL, cfg, RESP_OKAY);
            q = {};
            // Software stops writing once the FIFO is full
            for (k = 0; k < cap; k++) begin
                v = $urandom;
                wr(OFS_DATA, v, RESP_OKAY);
                q.push_back(v);
            end
            v = cfg | (32'(cap) << 8) | 32'h80;
            rc(OFS_CTRL, v, RESP_OKAY);
            if (i == 2) idle_mode <= 1'b1;
            wr(OFS_CTRL + 12'h8, 32'h10, RESP_OKAY);
            if (i == 2) begin
                repeat (40) @(posedge aclk);
                rc(OFS_CTRL, v | 32'h10, RESP_OKAY);
                idle_mode <= 1'b0;
            end
            for (n = 0; n < 100; n++) begin
                rd(OFS_ISTAT, v, r);
                if (v[0]) break;
            end
            if (n == 100) hang();
            // Early interrupt leaves the last word still shifting
            repeat (40) @(posedge aclk);
            chk({31'h0, irq}, {31'h0, i[0]});
            v = crc_ref(res, q, p, dws[i], pls[i], i[0], i[1]);
            rc(OFS_RESULT, v, RESP_OKAY);
            rc(OFS_CTRL, cfg | 32'h50, RESP_OKAY);
            wr(OFS_ISTAT, 32'h1, RESP_OKAY);
            rc(OFS_ISTAT, 32'h0, RESP_OKAY);
            chk({31'h0, irq}, 32'h0);
            wr(OFS_CTRL, 32'h0, RESP_OKAY);
        end
        finish_test();
    end
endmodule : tb
